// ===== design/etc_pkg.sv
// etc_pkg: constants for the event timestamp clock
// assumes a 200 MHz controller clock
package etc_pkg;
    localparam int unsigned CLK_HZ      = 200000000;
    localparam int unsigned SEC_NS      = 1000000000;
    localparam int unsigned CLK_NS      = SEC_NS / CLK_HZ;
    // cycles in one second of the controller clock
    localparam int unsigned SEC_CYCLES  = SEC_NS / CLK_NS;
    localparam int unsigned TS_W        = 32;
    localparam logic [31:0] TS_RESET    = 32'h0000_0000;
    // cycles from reset release until the controller is ready to read the clock source
    localparam int unsigned INIT_CYCLES = 16;
    // longest wait for an answer from the clock source
    localparam int unsigned RD_TIMEOUT  = 4096;

    typedef enum logic [2:0] {
        ETC_INIT  = 3'b000,
        ETC_WAIT  = 3'b001,
        ETC_READ  = 3'b010,
        ETC_RUN   = 3'b011
    } etc_state_type;
endpackage : etc_pkg

// ===== design/etc_sec_tick.sv
// etc_sec_tick: one-cycle pulse once per elapsed second
// assumes a free-running clock at the package rate
`timescale 1ns/1ps
module etc_sec_tick #(
    parameter int unsigned CYCLES = etc_pkg::SEC_CYCLES
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic restart,
    output logic      tick
);
    localparam int unsigned CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (restart || cnt_q == LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick <= 1'b0;
        end else begin
            tick <= !restart && cnt_q == LAST;
        end
    end
endmodule : etc_sec_tick

// ===== design/etc_clock.sv
// etc_clock: controller timestamp counter seeded from the system clock source
// Behaviour
// - after reset load counter from source read
// - source read after the start-up delay, whatever post_done is
// - abandon pending source read on post_done drop
// - read source at once when host is off
// - post already running: still read the source; start from zero if post_done drops mid-read or the read fails or times out
// - both time read commands return the counter
// - set command loads counter, never the source
// - counter value offered to internal subsystems
//
// assumes post_done comes from a pin; the source read engine (serial bus master)
// sits outside and answers rd_req with one rd_done or rd_fail pulse on clk
`timescale 1ns/1ps
module etc_clock #(
    parameter int unsigned SEC_CYCLES  = etc_pkg::SEC_CYCLES,
    parameter int unsigned RD_TIMEOUT  = etc_pkg::RD_TIMEOUT,
    parameter int unsigned INIT_CYCLES = etc_pkg::INIT_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        post_done,
    output logic             rd_req,
    output logic             rd_abort,
    input  wire logic        rd_done,
    input  wire logic        rd_fail,
    input  wire logic [31:0] rd_time,
    input  wire logic        set_time_cmd,
    input  wire logic [31:0] set_time,
    input  wire logic        read_log_time_cmd,
    input  wire logic        read_repository_time_cmd,
    output logic             rsp_valid,
    output logic [31:0]      rsp_time,
    output logic [31:0]      stamp,
    output logic             time_valid
);
    ////////////////////////////////////////////////////////////////////////////
    localparam int unsigned IW = $clog2(INIT_CYCLES + 1);
    localparam int unsigned TW = $clog2(RD_TIMEOUT + 1);
    localparam logic [IW-1:0] INIT_LAST = IW'(INIT_CYCLES);
    localparam logic [TW-1:0] TO_LAST   = TW'(RD_TIMEOUT);

    logic                  post_s1_q;
    logic                  post_s2_q;
    logic                  post_seen_q;
    logic [IW-1:0]         init_cnt_q;
    logic [TW-1:0]         to_cnt_q;
    etc_pkg::etc_state_type state_q;
    logic [31:0]           cnt_q;
    logic                  tick;
    logic                  load_zero;
    logic                  load_src;
    logic                  drop_read;

    ////////////////////////////////////////////////////////////////////////////
    // post_done synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            post_s1_q <= 1'b0;
            post_s2_q <= 1'b0;
        end else begin
            post_s1_q <= post_done;
            post_s2_q <= post_s1_q;
        end
    end

    // post_seen_q: host is past reset (post running or done) since last check
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            post_seen_q <= 1'b0;
        end else begin
            post_seen_q <= post_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // start-up delay until the controller is ready to read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            init_cnt_q <= '0;
        end else if (state_q == etc_pkg::ETC_INIT && init_cnt_q != INIT_LAST) begin
            init_cnt_q <= init_cnt_q + IW'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            to_cnt_q <= '0;
        end else if (state_q == etc_pkg::ETC_READ) begin
            to_cnt_q <= to_cnt_q + TW'(1);
        end else begin
            to_cnt_q <= '0;
        end
    end

    // a post_done fall during a read means the host was reset: give up the bus
    assign drop_read = state_q == etc_pkg::ETC_READ && post_seen_q && !post_s2_q;
    assign load_src  = state_q == etc_pkg::ETC_READ && rd_done && !drop_read;
    // failed, timed-out or abandoned read: count up from zero; an answer that
    // lands in the timeout cycle still wins
    assign load_zero = drop_read
                    || (state_q == etc_pkg::ETC_READ && !drop_read && !rd_done
                        && (rd_fail || to_cnt_q == TO_LAST));

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= etc_pkg::ETC_INIT;
        end else begin
            unique case (state_q)
                etc_pkg::ETC_INIT: begin
                    if (init_cnt_q == INIT_LAST) begin
                        // post_done low here is taken as host off
                        state_q <= etc_pkg::ETC_READ;
                    end
                end
                etc_pkg::ETC_WAIT: begin
                    if (post_s2_q) begin
                        state_q <= etc_pkg::ETC_READ;
                    end
                end
                etc_pkg::ETC_READ: begin
                    if (drop_read || rd_done || rd_fail || to_cnt_q == TO_LAST) begin
                        state_q <= etc_pkg::ETC_RUN;
                    end
                end
                etc_pkg::ETC_RUN: begin
                    state_q <= etc_pkg::ETC_RUN;
                end
                default: begin
                    state_q <= etc_pkg::ETC_INIT;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_req <= 1'b0;
        end else begin
            // held for the whole read; dropped at once on abandon
            rd_req <= state_q == etc_pkg::ETC_READ && !drop_read && !rd_done
                      && !rd_fail && to_cnt_q != TO_LAST;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_abort <= 1'b0;
        end else begin
            rd_abort <= drop_read;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    etc_sec_tick #(
        .CYCLES  (SEC_CYCLES)
    ) u_tick (
        .clk     (clk),
        .rstn    (rstn),
        .restart (load_src || load_zero || set_time_cmd),
        .tick    (tick)
    );

    // set command beats loads from the source; the source is never written
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= etc_pkg::TS_RESET;
        end else if (set_time_cmd) begin
            cnt_q <= set_time;
        end else if (load_src) begin
            cnt_q <= rd_time;
        end else if (load_zero) begin
            cnt_q <= etc_pkg::TS_RESET;
        end else if (tick) begin
            cnt_q <= cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            time_valid <= 1'b0;
        end else if (set_time_cmd || load_src) begin
            time_valid <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stamp <= etc_pkg::TS_RESET;
        end else begin
            stamp <= cnt_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rsp_valid <= 1'b0;
            rsp_time  <= etc_pkg::TS_RESET;
        end else begin
            rsp_valid <= read_log_time_cmd || read_repository_time_cmd;
            rsp_time  <= cnt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    a_read_gated: assert property (@(posedge clk) disable iff (!rstn)
        $rose(rd_req) |-> state_q == etc_pkg::ETC_READ)
        else $error("source read started outside read state");

    a_abort_drop: assert property (@(posedge clk) disable iff (!rstn)
        drop_read |=> rd_abort && !rd_req && state_q == etc_pkg::ETC_RUN)
        else $error("pending read not abandoned");

    a_src_load: assert property (@(posedge clk) disable iff (!rstn)
        load_src && !set_time_cmd |=> cnt_q == $past(rd_time))
        else $error("counter not loaded from source");

    a_zero_load: assert property (@(posedge clk) disable iff (!rstn)
        load_zero && !set_time_cmd |=> cnt_q == 32'h0000_0000)
        else $error("counter not cleared");

    a_set_load: assert property (@(posedge clk) disable iff (!rstn)
        set_time_cmd |=> cnt_q == $past(set_time))
        else $error("set time not applied");

    a_set_no_src: assert property (@(posedge clk) disable iff (!rstn)
        set_time_cmd && state_q == etc_pkg::ETC_RUN |=> !rd_req)
        else $error("set time reached the source");

    a_rsp_value: assert property (@(posedge clk) disable iff (!rstn)
        (read_log_time_cmd || read_repository_time_cmd) |=>
            rsp_valid && rsp_time == $past(cnt_q))
        else $error("time read answer wrong");

    a_stamp_follow: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> stamp == $past(cnt_q))
        else $error("stamp lags counter");

    a_tick_step: assert property (@(posedge clk) disable iff (!rstn)
        tick && !set_time_cmd && !load_src && !load_zero |=>
            cnt_q == $past(cnt_q) + 32'h0000_0001)
        else $error("second tick not counted");

    a_no_drift: assert property (@(posedge clk) disable iff (!rstn)
        !tick && !set_time_cmd && !load_src && !load_zero |=> $stable(cnt_q))
        else $error("counter moved without cause");
endmodule : etc_clock

// ===== verif/etc_src_model.sv
// etc_src_model: behavioural clock source read engine for the bench
// assumes rd_req is held until one rd_done or rd_fail pulse comes back
`timescale 1ns/1ps
module etc_src_model (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        rd_req,
    input  wire logic [1:0]  mode,
    input  wire logic [31:0] value,
    output logic             rd_done,
    output logic             rd_fail,
    output logic [31:0]      rd_time
);
    // mode 0 prompt, 1 slow, 2 failing, 3 silent
    logic [3:0] cnt_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q   <= 4'h0;
            rd_done <= 1'b0;
            rd_fail <= 1'b0;
            rd_time <= 32'h0;
        end else begin
            rd_done <= 1'b0;
            rd_fail <= 1'b0;
            // time lines invert every cycle outside an answer; the last answer shows again every other cycle
            rd_time <= ~rd_time;
            cnt_q   <= 4'h0;
            if (rd_req && !rd_done && !rd_fail) begin
                cnt_q <= cnt_q + 4'h1;
                if (mode != 2'h3 && cnt_q == ((mode == 2'h0) ? 4'h2 : 4'h9)) begin
                    rd_done <= (mode != 2'h2);
                    rd_fail <= (mode == 2'h2);
                    if (mode != 2'h2) begin
                        rd_time <= value;
                    end
                end
            end
        end
    end
endmodule : etc_src_model

// ===== verif/tb_top.sv
// tb_top: self-checking bench for the event timestamp clock
// assumes shortened second and read timeout counts
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0, rstn = 1'b0, post_done = 1'b0;
    logic        set_time_cmd = 1'b0, read_log_time_cmd = 1'b0;
    logic        read_repository_time_cmd = 1'b0;
    logic [31:0] set_time = 32'h0, src_value = 32'h0;
    logic [1:0]  mode = 2'h0;
    logic        rd_req, rd_abort, rd_done, rd_fail, rsp_valid, time_valid;
    logic [31:0] rd_time, rsp_time, stamp;
    logic [31:0] exp_q[$];
    logic [15:0] seed = 16'd53700;
    int          errors = 0, comparisons = 0, cycles = 0, k;

    always #2.5 clk = ~clk;

    etc_clock #(.SEC_CYCLES(10), .RD_TIMEOUT(20), .INIT_CYCLES(16)) dut (
        .clk(clk), .rstn(rstn), .post_done(post_done), .rd_req(rd_req),
        .rd_abort(rd_abort), .rd_done(rd_done), .rd_fail(rd_fail), .rd_time(rd_time),
        .set_time_cmd(set_time_cmd), .set_time(set_time),
        .read_log_time_cmd(read_log_time_cmd),
        .read_repository_time_cmd(read_repository_time_cmd),
        .rsp_valid(rsp_valid), .rsp_time(rsp_time), .stamp(stamp), .time_valid(time_valid));
    etc_src_model src (.clk(clk), .rstn(rstn), .rd_req(rd_req), .mode(mode),
        .value(src_value), .rd_done(rd_done), .rd_fail(rd_fail), .rd_time(rd_time));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        rnd  = {seed, ~seed};
    endfunction : rnd

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic do_reset(input logic pd, input logic [1:0] m);
        // let a pending answer reach the monitor before reset clears it
        if (rstn === 1'b1) begin
            cyc(2);
        end
        rstn      = 1'b0;
        post_done = pd;
        mode      = m;
        src_value = rnd();
        cyc(3);
        rstn = 1'b1;
        k    = 0;
        while (rd_req !== 1'b1 && k < 100) begin
            cyc(1);
            k++;
        end
    endtask : do_reset

    task automatic wait_read_end();
        k = 0;
        while (rd_req !== 1'b0 && k < 40) begin
            cyc(1);
            k++;
        end
    endtask : wait_read_end

    // read command; the expected answer waits in the queue for the monitor
    task automatic rd_cmd(input logic repo, input logic [31:0] exp);
        exp_q.push_back(exp);
        read_repository_time_cmd = repo;
        read_log_time_cmd        = !repo;
        cyc(1);
        read_repository_time_cmd = 1'b0;
        read_log_time_cmd        = 1'b0;
    endtask : rd_cmd

    task automatic set_cmd(input logic [31:0] v);
        set_time_cmd = 1'b1;
        set_time     = v;
        cyc(1);
        set_time_cmd = 1'b0;
    endtask : set_cmd

    ////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            tally_and_finish();
        end
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected response", 32'h1, 32'h0);
            end else begin
                chk("rsp_time", rsp_time, exp_q.pop_front());
            end
        end
    end

    initial begin
        logic [31:0] v;
        for (int m = 0; m < 2; m++) begin
            do_reset(1'b0, m[1:0]);
            chk("read started", {31'h0, rd_req}, 32'h1);
            wait_read_end();
            chk("time_valid", {31'h0, time_valid}, 32'h1);
            rd_cmd(1'b0, src_value);
            $display("source load test mode %0d done", m);
        end
        v = rnd();
        set_cmd(v);
        cyc(1);
        chk("stamp", stamp, v);
        chk("no source access", {31'h0, rd_req}, 32'h0);
        rd_cmd(1'b1, v);
        rd_cmd(1'b0, v);
        v = rnd();
        set_cmd(v);
        cyc(14);
        rd_cmd(1'b1, v + 32'h1);
        $display("command test done");
        do_reset(1'b1, 2'h3);
        cyc(3);
        post_done = 1'b0;
        k         = 0;
        while (rd_abort !== 1'b1 && k < 10) begin
            cyc(1);
            k++;
        end
        chk("rd_abort", {31'h0, rd_abort}, 32'h1);
        cyc(1);
        chk("rd_req after abort", {31'h0, rd_req}, 32'h0);
        rd_cmd(1'b0, 32'h0);
        $display("abort test done");
        do_reset(1'b0, 2'h2);
        wait_read_end();
        chk("time_valid after fail", {31'h0, time_valid}, 32'h0);
        rd_cmd(1'b1, 32'h0);
        cyc(3);
        chk("responses left", exp_q.size(), 32'h0);
        $display("fail test done");
        tally_and_finish();
    end
endmodule : tb_top
